// *** rtl/sdhdrp_receiver.sv ***
`timescale 1ns/10ps
// How it works
// - sample all drop lines on falling clock
// - bus clock is timing; detect its loss
// - odd parity over byte, window, marker
// - tracking: parity covers byte and c1 only
// - c1: one-cycle high pulse, window low
// - no tracking: j1 pulse inside window
// - no j1 supplied: enable tracking
// - or marker and separate c1 inputs
// - tracking: c1 offset delay up to frame
// - window ignored while tracking enabled
// - line 7 is msb, first bit
// - unused separate c1 tied low
module sdhdrp_receiver
  import sdhdrp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  sdhdrp_if.receiver bus,
  input wire logic i_tracking_en,
  input wire logic i_parity_data_only,
  input wire logic i_receive_offset_delay_ctrl,
  input wire logic [11:0] i_offset_bytes,
  input wire logic i_parity_err_clear,
  output logic o_loss_of_clock,
  output logic o_parity_err_pulse,
  output logic o_parity_err_flag,
  output logic o_valid,
  input wire logic i_ready,
  output logic o_overflow,
  output logic [7:0] o_byte,
  output logic o_window,
  output logic o_c1,
  output logic o_j1
);
  logic [1:0] clk_s_q;
  logic [1:0] dat_s_q [12];
  logic clk_prev_q;
  logic fall;
  logic [7:0] smp_byte;
  logic smp_par;
  logic smp_win;
  logic smp_mark;
  logic smp_c1s;
  logic marker;
  logic calc;
  logic [7:0] loc_q;
  logic [11:0] pos_q;
  logic [11:0] pos_now;
  logic c1_now;
  logic j1_now;
  logic win_now;
  logic [WORD_W-1:0] word;
  logic push_q;
  logic [WORD_W-1:0] word_q;
  logic fifo_rdy;
  logic [WORD_W-1:0] out_word;

  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  // pins change on the rising edge, so they are stable a full half
  // period around the falling edge and survive the same 2-flop delay
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      clk_s_q <= '0;
      clk_prev_q <= 1'b0;
    end
    else
    begin
      clk_s_q <= {clk_s_q[0], bus.drop_bus_clock};
      clk_prev_q <= clk_s_q[1];
    end
  end
  genvar g;
  generate
    for (g = 0; g < 12; g++)
    begin : g_sync
      logic pin;
      if (g < 8)
      begin : g_b
        assign pin = bus.drop_byte_lines[g];
      end
      else if (g == 8)
      begin : g_p
        assign pin = bus.drop_parity_bit;
      end
      else if (g == 9)
      begin : g_w
        assign pin = bus.drop_payload_window;
      end
      else if (g == 10)
      begin : g_m
        assign pin = bus.drop_frame_path_marker;
      end
      else
      begin : g_s
        assign pin = bus.drop_separate_frame_pulse;
      end
      always_ff @(posedge i_sys_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          dat_s_q[g] <= '0;
        end
        else
        begin
          dat_s_q[g] <= {dat_s_q[g][0], pin};
        end
      end
    end
  endgenerate

  assign fall = clk_prev_q && !clk_s_q[1];
  // line 7 stays bit 7: msb, first received
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      smp_byte[i] = dat_s_q[i][1];
    end
  end
  assign smp_par = dat_s_q[8][1];
  assign smp_win = dat_s_q[9][1];
  // both leads synchronised apart; no logic ahead of the flops
  assign smp_mark = dat_s_q[10][1];
  assign smp_c1s = dat_s_q[11][1];
  assign marker = smp_mark | smp_c1s;

  // ------------------------------------------------------------
  // loss of clock
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      loc_q <= '0;
    end
    else if (fall)
    begin
      loc_q <= '0;
    end
    else if (loc_q != LOC_CNT)
    begin
      loc_q <= loc_q + 8'h01;
    end
  end
  assign o_loss_of_clock = (loc_q == LOC_CNT);

  // ------------------------------------------------------------
  // parity check
  // ------------------------------------------------------------
  always_comb
  begin
    calc = ^{smp_byte, smp_par};
    if (!i_parity_data_only)
    begin
      calc = calc ^ marker;
      if (!i_tracking_en)
      begin
        calc = calc ^ smp_win;
      end
      // tracking: window left out of coverage
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_parity_err_pulse <= 1'b0;
      o_parity_err_flag <= 1'b0;
    end
    else
    begin
      o_parity_err_pulse <= fall && !calc;
      // a new error wins over a clear in the same cycle
      if (fall && !calc)
      begin
        o_parity_err_flag <= 1'b1;
      end
      else if (i_parity_err_clear)
      begin
        o_parity_err_flag <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // frame markers
  // ------------------------------------------------------------
  // tracking mode: c1 from the marker, moved later by the chosen
  // offset inside one frame; the window input is not used
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pos_q <= FRAME_LAST;
    end
    else if (fall)
    begin
      if (marker && i_tracking_en)
      begin
        pos_q <= '0;
      end
      else if (pos_q != FRAME_LAST)
      begin
        pos_q <= pos_q + 12'h001;
      end
    end
  end
  // position of the byte on the pins now; a marker restarts it at zero
  assign pos_now = marker ? 12'h000 :
                   ((pos_q == FRAME_LAST) ? FRAME_LAST : pos_q + 12'h001);
  always_comb
  begin
    if (i_tracking_en)
    begin
      win_now = 1'b0;
      j1_now = 1'b0;
      if (i_receive_offset_delay_ctrl && i_offset_bytes <= FRAME_LAST)
      begin
        // a saturated count means no c1 seen lately: stay quiet
        c1_now = (pos_now == i_offset_bytes) && (marker || pos_q != FRAME_LAST);
      end
      else
      begin
        c1_now = marker;
      end
    end
    else
    begin
      win_now = smp_win;
      c1_now = marker && !smp_win;
      j1_now = marker && smp_win;
    end
  end
  assign word = {c1_now, j1_now, win_now, smp_byte};

  // ------------------------------------------------------------
  // buffering
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      push_q <= 1'b0;
      word_q <= '0;
      o_overflow <= 1'b0;
    end
    else
    begin
      push_q <= fall;
      if (fall)
      begin
        word_q <= word;
      end
      // the bus cannot stall, so a full buffer drops and flags
      o_overflow <= push_q && !fifo_rdy;
    end
  end

  sdhdrp_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) sdhdrp_fifo_inst (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_in_valid(push_q),
    .o_in_ready(fifo_rdy),
    .i_in_data(word_q),
    .o_out_valid(o_valid),
    .i_out_ready(i_ready),
    .o_out_data(out_word)
  );
  assign o_byte = out_word[BYTE_W-1:0];
  assign o_window = out_word[WORD_WIN_BIT];
  assign o_j1 = out_word[WORD_J1_BIT];
  assign o_c1 = out_word[WORD_C1_BIT];
endmodule // sdhdrp_receiver

// *** inc/sdhdrp_pkg.sv ***
package sdhdrp_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int SYS_CLK_KHZ = 125000;
  localparam int BUS_CLK_KHZ = 19440;
  // source side divider: half period in system cycles (125 / 19.44 ~ 6.4 per period, halved to 3)
  localparam int BUS_HALF_CYC = (SYS_CLK_KHZ / BUS_CLK_KHZ) / 2;
  localparam logic [3:0] BUS_HALF_CNT = 4'(BUS_HALF_CYC - 1);
  // loss of clock: no drop bus clock falling edge for this many nanoseconds (50 system cycles)
  localparam int LOC_NS = 400;
  localparam int SYS_PERIOD_NS = 8;
  localparam int LOC_CYC = LOC_NS / SYS_PERIOD_NS;
  localparam logic [7:0] LOC_CNT = 8'(LOC_CYC);
  // frame length in bytes (9 rows x 270 columns)
  localparam int FRAME_BYTES = 2430;
  localparam logic [11:0] FRAME_LAST = 12'(FRAME_BYTES - 1);
  // ------------------------------------------------------------
  // widths and buffering
  // ------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  // fifo word: {c1, j1, window, byte}
  localparam int WORD_W = BYTE_W + 3;
  localparam int WORD_C1_BIT = 10;
  localparam int WORD_J1_BIT = 9;
  localparam int WORD_WIN_BIT = 8;
endpackage

// *** inc/sdhdrp_if.sv ***
`timescale 1ns/10ps
interface sdhdrp_if;
  logic drop_bus_clock;
  logic [7:0] drop_byte_lines;
  logic drop_parity_bit;
  logic drop_payload_window;
  logic drop_frame_path_marker;
  logic drop_separate_frame_pulse;

  modport source (
    output drop_bus_clock,
    output drop_byte_lines,
    output drop_parity_bit,
    output drop_payload_window,
    output drop_frame_path_marker,
    output drop_separate_frame_pulse
  );
  modport receiver (
    input drop_bus_clock,
    input drop_byte_lines,
    input drop_parity_bit,
    input drop_payload_window,
    input drop_frame_path_marker,
    input drop_separate_frame_pulse
  );
endinterface

// *** rtl/sdhdrp_fifo.sv ***
`timescale 1ns/10ps
module sdhdrp_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_q[rd_q];

  always_ff @(posedge i_sys_clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sdhdrp_fifo

// *** rtl/sdhdrp_source.sv ***
`timescale 1ns/10ps
// upstream bus source: makes the drop bus clock by a divider and sends
// one user byte per bus clock period, changing lines on the rising edge
module sdhdrp_source
  import sdhdrp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_tracking_en,
  input wire logic i_parity_data_only,
  input wire logic i_use_separate_c1,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [7:0] i_byte,
  input wire logic i_window,
  input wire logic i_c1,
  input wire logic i_j1,
  sdhdrp_if.source bus
);
  logic [3:0] div_q;
  logic clk_q;
  logic rise;
  logic [7:0] byte_q;
  logic win_q;
  logic mark_q;
  logic c1s_q;
  logic par_q;
  logic par_d;
  logic win_eff;
  logic mark_eff;

  // ------------------------------------------------------------
  // clock divider
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      div_q <= '0;
      clk_q <= 1'b0;
    end
    else if (div_q == BUS_HALF_CNT)
    begin
      div_q <= '0;
      clk_q <= ~clk_q;
    end
    else
    begin
      div_q <= div_q + 4'h1;
    end
  end
  assign rise = (div_q == BUS_HALF_CNT) && !clk_q;
  // one byte taken per bus clock; idle slots carry zeros
  assign o_ready = rise;

  // ------------------------------------------------------------
  // bus lines and parity
  // ------------------------------------------------------------
  // window driven in every mode; a tracking receiver must not lean on it
  assign win_eff = i_valid && i_window;
  // j1 only sent without tracking; c1 goes on one of two leads
  assign mark_eff = i_valid && ((i_c1 && !i_use_separate_c1) ||
                    (i_j1 && i_window && !i_tracking_en));
  always_comb
  begin
    par_d = ~(^(i_valid ? i_byte : 8'h00));
    if (!i_parity_data_only)
    begin
      par_d = par_d ^ mark_eff ^ (i_valid && i_c1 && i_use_separate_c1);
      if (!i_tracking_en)
      begin
        par_d = par_d ^ win_eff;
      end
    end
    // data only overrides the other coverage choices
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      byte_q <= 8'h00;
      win_q <= 1'b0;
      mark_q <= 1'b0;
      c1s_q <= 1'b0;
      par_q <= 1'b1;
    end
    else if (rise)
    begin
      byte_q <= i_valid ? i_byte : 8'h00;
      win_q <= win_eff;
      mark_q <= mark_eff;
      // unused separate lead stays low
      c1s_q <= i_valid && i_c1 && i_use_separate_c1;
      par_q <= par_d;
    end
  end

  assign bus.drop_bus_clock = clk_q;
  assign bus.drop_byte_lines = byte_q;
  assign bus.drop_parity_bit = par_q;
  assign bus.drop_payload_window = win_q;
  assign bus.drop_frame_path_marker = mark_q;
  assign bus.drop_separate_frame_pulse = c1s_q;
endmodule // sdhdrp_source

// *** tb/sdhdrp_props.sv ***
`timescale 1ns/10ps
module sdhdrp_props (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_tracking_en,
  input wire logic i_parity_data_only,
  input wire logic i_use_separate_c1,
  input wire logic drop_bus_clock,
  input wire logic [7:0] drop_byte_lines,
  input wire logic drop_parity_bit,
  input wire logic drop_payload_window,
  input wire logic drop_frame_path_marker,
  input wire logic drop_separate_frame_pulse
);
  // ------------------------------------------------------------
  // wire checks, reset is the source's own
  // ------------------------------------------------------------
  logic mark_c;
  // composite marker: both leads count in the parity
  assign mark_c = drop_frame_path_marker | drop_separate_frame_pulse;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  chk_par_full:
    assert property ($fell(drop_bus_clock) && !i_tracking_en && !i_parity_data_only
      |-> ^{drop_byte_lines, drop_payload_window, mark_c, drop_parity_bit})
    else $error("full coverage parity wrong");
  chk_par_track:
    assert property ($fell(drop_bus_clock) && i_tracking_en && !i_parity_data_only
      |-> ^{drop_byte_lines, mark_c, drop_parity_bit})
    else $error("tracking parity wrong");
  chk_par_data:
    assert property ($fell(drop_bus_clock) && i_parity_data_only
      |-> ^{drop_byte_lines, drop_parity_bit})
    else $error("data only parity wrong");
  chk_clk_high:
    assert property ($rose(drop_bus_clock) |-> drop_bus_clock[*3] ##1 !drop_bus_clock)
    else $error("bus clock high phase wrong");
  chk_clk_low:
    assert property ($fell(drop_bus_clock) |-> !drop_bus_clock[*3] ##1 drop_bus_clock)
    else $error("bus clock low phase wrong");
  chk_lines_stable:
    assert property (!$rose(drop_bus_clock)
      |-> $stable({drop_byte_lines, drop_parity_bit, drop_payload_window}))
    else $error("lines moved off the rising bus edge");
  chk_marker_width:
    assert property ($rose(drop_frame_path_marker)
      |-> drop_frame_path_marker[*6] ##1 !drop_frame_path_marker)
    else $error("marker not one bus cycle");
  chk_sep_unused:
    assert property (!i_use_separate_c1 |-> !drop_separate_frame_pulse)
    else $error("unused separate lead not low");
endmodule // sdhdrp_props

// *** tb/tb_sdh_drop_bus_receiver.sv ***
`timescale 1ns/10ps
module tb_sdh_drop_bus_receiver
  import sdhdrp_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hold = 1'b0;
  logic srst;
  logic ts = 1'b0, ps = 1'b0, sep = 1'b0, sv = 1'b0, sw = 1'b0, sc = 1'b0, sj = 1'b0;
  logic [7:0] sb = 8'h00;
  logic [11:0] ofs = 12'h003;
  logic tr = 1'b0, pr = 1'b0, odc = 1'b0, pclr = 1'b0, rr = 1'b1;
  logic rdy, los, pp, pf, rv, ovf, rw, rc, rj;
  logic [7:0] rb;
  logic [10:0] q[$];
  int fail_count = 0, compares = 0, np = 0, no = 0;
  sdhdrp_if bus ();
  // holding the source in reset stops the bus clock
  assign srst = rst | hold;
  always #4 clk = ~clk;
  sdhdrp_source sdhdrp_source_inst (.i_sys_clk(clk), .i_rst(srst), .i_tracking_en(ts),
    .i_parity_data_only(ps), .i_use_separate_c1(sep), .i_valid(sv), .o_ready(rdy),
    .i_byte(sb), .i_window(sw), .i_c1(sc), .i_j1(sj), .bus(bus.source));
  sdhdrp_receiver sdhdrp_receiver_inst (.i_sys_clk(clk), .i_rst(rst), .bus(bus.receiver),
    .i_tracking_en(tr), .i_parity_data_only(pr), .i_receive_offset_delay_ctrl(odc),
    .i_offset_bytes(ofs), .i_parity_err_clear(pclr), .o_loss_of_clock(los),
    .o_parity_err_pulse(pp), .o_parity_err_flag(pf), .o_valid(rv), .i_ready(rr),
    .o_overflow(ovf), .o_byte(rb), .o_window(rw), .o_c1(rc), .o_j1(rj));
  sdhdrp_props sdhdrp_props_inst (.i_sys_clk(clk), .i_rst(srst), .i_tracking_en(ts),
    .i_parity_data_only(ps), .i_use_separate_c1(sep),
    .drop_bus_clock(bus.drop_bus_clock), .drop_byte_lines(bus.drop_byte_lines),
    .drop_parity_bit(bus.drop_parity_bit), .drop_payload_window(bus.drop_payload_window),
    .drop_frame_path_marker(bus.drop_frame_path_marker),
    .drop_separate_frame_pulse(bus.drop_separate_frame_pulse));

  // ------------------------------------------------------------
  // monitor and tasks
  // ------------------------------------------------------------
  // idle zero bytes flow all the time, so only non-zero words are kept
  always @(posedge clk)
  begin
    if (rv === 1'b1 && rr === 1'b1 && {rc, rj, rw, rb} !== 11'h000)
      q.push_back({rc, rj, rw, rb});
    if (pp === 1'b1)
      np++;
    if (ovf === 1'b1)
      no++;
  end

  task automatic chk(input string n, input logic [10:0] s, input logic [10:0] e);
    compares++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // f = {window, c1, j1}
  task automatic send(input logic [7:0] b, input logic [2:0] f);
    @(posedge clk);
    sv <= 1'b1;
    sb <= b;
    {sw, sc, sj} <= f;
    do @(negedge clk); while (rdy !== 1'b1);
    @(posedge clk);
    sv <= 1'b0;
  endtask

  // m = {src track, src data only, separate c1, rx track, rx data only, offset ctrl}
  task automatic mode(input logic [5:0] m);
    @(posedge clk);
    hold <= 1'b1;
    {ts, ps, sep, tr, pr, odc} <= m;
    repeat (3) @(posedge clk);
    hold <= 1'b0;
    repeat (20) @(posedge clk);
    q.delete();
  endtask

  task automatic waitq(input int n);
    for (int i = 0; i < 300 && q.size() < n; i++)
      @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #200000;
    fail_count++;
    print_verdict();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    mode(6'b000000);
    send(8'h81, 3'b010);
    send(8'hff, 3'b100);
    send(8'h5a, 3'b101);
    waitq(3);
    chk("c1 word", q[0], 11'h481);
    chk("payload word", q[1], 11'h1ff);
    chk("j1 word", q[2], 11'h35a);
    chk("parity errors", 11'(np), 11'h000);
    mode(6'b001000);
    send(8'h42, 3'b010);
    waitq(1);
    chk("separate c1", q[0], 11'h442);
    // source covers data only, receiver expects full coverage
    mode(6'b010000);
    send(8'h5a, 3'b100);
    waitq(1);
    chk("bad parity", 11'(np), 11'h001);
    chk("sticky flag", 11'(pf), 11'h001);
    pclr <= 1'b1;
    @(posedge clk);
    pclr <= 1'b0;
    repeat (2) @(posedge clk);
    chk("flag cleared", 11'(pf), 11'h000);
    mode(6'b010010);
    send(8'h5a, 3'b100);
    waitq(1);
    chk("data only", 11'(np), 11'h001);
    mode(6'b100100);
    send(8'h3c, 3'b100);
    waitq(1);
    chk("tracking window", q[0], 11'h03c);
    chk("tracking parity", 11'(np), 11'h001);
    mode(6'b100101);
    send(8'h11, 3'b010);
    for (int i = 1; i < 5; i++)
      send(8'(8'h20 + i), 3'b000);
    waitq(5);
    chk("c1 moved off", q[0], 11'h011);
    chk("c1 at offset", q[3], 11'h423);
    ofs <= 12'h000;
    mode(6'b100101);
    send(8'h11, 3'b010);
    waitq(1);
    chk("c1 zero offset", q[0], 11'h411);
    // stalled reader: fifo fills and refuses
    rr <= 1'b0;
    repeat (100) @(posedge clk);
    chk("stall valid", 11'(rv), 11'h001);
    chk("overflow seen", 11'(no > 0), 11'h001);
    rr <= 1'b1;
    hold <= 1'b1;
    repeat (LOC_CYC + 10) @(posedge clk);
    chk("clock lost", 11'(los), 11'h001);
    hold <= 1'b0;
    repeat (40) @(posedge clk);
    chk("clock back", 11'(los), 11'h000);
    print_verdict();
  end
endmodule // tb_sdh_drop_bus_receiver
